/* File: logic/pmir_device.sv */
// Device end: identifier, indirect access and status registers.
// Contract
// - Command field selects address or data mode.
// - Target device address routes indirect accesses.
// - Address 11111 selects vendor space up to 04d1.
// - Address 00001 selects the first MMD space.
// - Other target addresses are ignored.
// - Command zero accesses pointer, otherwise data.
// - Channel ok bit latches low.
// - Descrambler lock bit latches low.
// - Interrupt pin flag cleared by 0x12 read.
// - Loopback and duplex status bits read-only.
// - Link status bit shows current link.
// - Revision field in low four bits.
// - Model field in bits nine to four.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pmir_device #(
  parameter logic [5:0] org_low = 6'h15,
  parameter logic [5:0] model = 6'h2a,
  parameter logic [3:0] revision = 4'h1,
  parameter int words = pmir_pkg::pmir_mmd_words
) (
  input wire logic hclk,
  input wire logic hresetn,
  pmir_if.dev bus,
  input wire logic chan_ok_in,
  input wire logic lock_in,
  input wire logic irq_out_in,
  input wire logic loopback_in,
  input wire logic full_duplex_in,
  input wire logic link_in
);
  import pmir_pkg::*;
  // Values of org_low, model and revision are arbitrary.
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] ptr_vendor;
    logic [15:0] ptr_mmd1;
    logic chan_ok;
    logic lock;
    logic irq_seen;
    logic ack;
    logic [15:0] rdata;
    logic [2:0] s1;
    logic [2:0] s2;
    logic s3;
    logic [2:0] d1;
    logic [2:0] d2;
  } pmir_dev_t;
  pmir_dev_t st;
  pmir_dev_t next_st;
  logic [15:0] vend_mem [words];
  logic [15:0] mmd1_mem [words];
  logic hit;
  logic is_vendor;
  logic [15:0] ptr;
  logic [15:0] cur_data;
  logic do_write;
  logic inc;
  pmir_cmd_t cmd;
  localparam int aw = $clog2(words);
  assign bus.ack = st.ack;
  assign bus.rdata = st.rdata;
  always_comb begin
    next_st = st;
    // Pin levels pass two flip-flops before use.
    next_st.s1 = {chan_ok_in, lock_in, irq_out_in};
    next_st.s2 = st.s1;
    next_st.d1 = {loopback_in, full_duplex_in, link_in};
    next_st.d2 = st.d1;
    next_st.s3 = st.s2[0];
    next_st.ack = 1'b0;
    cmd = pmir_cmd_t'(st.ctrl[pmir_cmd_hi:pmir_cmd_lo]);
    is_vendor = st.ctrl[pmir_target_hi:0] == pmir_target_vendor;
    hit = is_vendor || st.ctrl[pmir_target_hi:0] == pmir_target_mmd1;
    ptr = is_vendor ? st.ptr_vendor : st.ptr_mmd1;
    cur_data = is_vendor ? vend_mem[ptr[aw-1:0]] : mmd1_mem[ptr[aw-1:0]];
    // Vendor space ends at its last register.
    if (is_vendor && ptr > pmir_vendor_last) begin
      cur_data = 16'h0000;
    end
    do_write = 1'b0;
    inc = 1'b0;
    if (!st.s2[2]) begin
      next_st.chan_ok = 1'b0;
    end
    if (!st.s2[1]) begin
      next_st.lock = 1'b0;
    end
    if (bus.req && !st.ack) begin
      next_st.ack = 1'b1;
      next_st.rdata = 16'h0000;
      unique case (bus.addr)
        pmir_off_id_low: begin
          next_st.rdata = {org_low, model, revision};
        end
        pmir_off_ctrl: begin
          next_st.rdata = {st.ctrl[15:14], 9'h000, st.ctrl[4:0]};
          if (bus.wr) begin
            next_st.ctrl = {bus.wdata[15:14], 9'h000, bus.wdata[4:0]};
          end
        end
        pmir_off_addr_data: begin
          if (hit) begin
            if (cmd == pmir_cmd_addr) begin
              next_st.rdata = ptr;
              if (bus.wr && is_vendor) begin
                next_st.ptr_vendor = bus.wdata;
              end else if (bus.wr) begin
                next_st.ptr_mmd1 = bus.wdata;
              end
            end else begin
              next_st.rdata = cur_data;
              do_write = bus.wr && !(is_vendor && ptr > pmir_vendor_last);
              inc = (cmd == pmir_cmd_data_inc_rw) ||
                    (cmd == pmir_cmd_data_inc_w && bus.wr);
            end
          end
        end
        pmir_off_status: begin
          next_st.rdata = {5'h00, st.chan_ok, st.lock, 1'b0, st.irq_seen,
                           3'h0, st.d2[2], st.d2[1], 1'b0, st.d2[0]};
          if (!bus.wr) begin
            next_st.chan_ok = st.s2[2];
            next_st.lock = st.s2[1];
          end
        end
        pmir_off_int_status1: begin
          if (!bus.wr) begin
            next_st.irq_seen = 1'b0;
          end
        end
        default: begin
          next_st.rdata = 16'h0000;
        end
      endcase
    end
    if (st.s2[0] && !st.s3) begin
      next_st.irq_seen = 1'b1;
    end
    if (inc && is_vendor) begin
      next_st.ptr_vendor = st.ptr_vendor + 16'h0001;
    end else if (inc) begin
      next_st.ptr_mmd1 = st.ptr_mmd1 + 16'h0001;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.ctrl <= pmir_ctrl_reset;
      st.chan_ok <= 1'b0;
      st.d2 <= 3'b010;
      st.d1 <= 3'b010;
    end else begin
      st <= next_st;
    end
  end
  // Memory storage kept outside the reset struct to stay a plain array.
  always_ff @(posedge hclk) begin
    if (do_write && is_vendor) begin
      vend_mem[ptr[aw-1:0]] <= bus.wdata;
    end else if (do_write) begin
      mmd1_mem[ptr[aw-1:0]] <= bus.wdata;
    end
  end
endmodule : pmir_device
`default_nettype wire

/* File: logic/pmir_host.sv */
// Host end: AHB-Lite slave that issues register accesses to the device.
`timescale 1ns/10ps
`default_nettype none
module pmir_host (
  input wire logic hclk,
  input wire logic hresetn,
  pmir_if.host bus,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq
);
  import pmir_pkg::*;
  typedef struct packed {
    logic dph;
    logic dwr;
    logic [7:0] daddr;
    logic req;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic [31:0] hrdata;
  } pmir_host_t;
  pmir_host_t st;
  pmir_host_t next_st;
  assign bus.req = st.req;
  assign bus.wr = st.wr;
  assign bus.addr = st.addr;
  assign bus.wdata = st.wdata;
  assign hrdata = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(st.int_status & st.int_mask);
  always_comb begin
    next_st = st;
    next_st.dph = hsel && htrans[1];
    next_st.dwr = hwrite;
    next_st.daddr = haddr[7:0];
    next_st.hrdata = 32'h00000000;
    // Bit 0 marks access done, bit 1 marks read data ready.
    if (st.req && bus.ack) begin
      next_st.req = 1'b0;
      next_st.rdata = bus.rdata;
      next_st.int_status = st.int_status | {~st.wr, 1'b1};
    end
    if (st.dph && st.dwr) begin
      unique case (st.daddr)
        pmir_h_cmd: begin
          if (!st.req) begin
            next_st.req = 1'b1;
            next_st.wr = hwdata[8];
            next_st.addr = hwdata[4:0];
          end
        end
        pmir_h_wdata: next_st.wdata = hwdata[15:0];
        pmir_h_int_status: begin
          next_st.int_status = next_st.int_status & ~(hwdata[1:0] &
                               ~({~st.wr, 1'b1} & {2{st.req && bus.ack}}));
        end
        pmir_h_int_mask: next_st.int_mask = hwdata[1:0];
        default: next_st.int_mask = st.int_mask;
      endcase
    end
    if (!(hsel && htrans[1] && !hwrite)) begin
      next_st.hrdata = 32'h00000000;
    end else begin
      unique case (haddr[7:0])
        pmir_h_wdata: next_st.hrdata = {16'h0000, st.wdata};
        pmir_h_rdata: next_st.hrdata = {16'h0000, st.rdata};
        pmir_h_int_status: next_st.hrdata = {30'h0, st.int_status};
        pmir_h_int_mask: next_st.hrdata = {30'h0, st.int_mask};
        pmir_h_busy: next_st.hrdata = {31'h0, st.req};
        default: next_st.hrdata = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : pmir_host
`default_nettype wire

/* File: logic/pmir_if.sv */
// Register access carrier between management host and device.
`timescale 1ns/10ps
`default_nettype none
interface pmir_if;
  logic req;
  logic wr;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  modport dev (input req, input wr, input addr, input wdata,
               output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata,
                input ack, input rdata);
endinterface : pmir_if
`default_nettype wire

/* File: logic/pmir_pkg.sv */
// Constants and types shared by the management register ends.
package pmir_pkg;
  localparam logic [4:0] pmir_off_id_low = 5'h03;
  localparam logic [4:0] pmir_off_ctrl = 5'h0d;
  localparam logic [4:0] pmir_off_addr_data = 5'h0e;
  localparam logic [4:0] pmir_off_status = 5'h10;
  localparam logic [4:0] pmir_off_int_status1 = 5'h12;
  localparam logic [15:0] pmir_ctrl_reset = 16'h0000;
  localparam logic [15:0] pmir_addr_data_reset = 16'h0000;
  localparam logic [15:0] pmir_status_reset = 16'h0004;
  localparam int pmir_cmd_hi = 15;
  localparam int pmir_cmd_lo = 14;
  localparam int pmir_target_hi = 4;
  localparam int pmir_chan_ok_bit = 10;
  localparam int pmir_lock_bit = 9;
  localparam int pmir_irq_pin_bit = 7;
  localparam int pmir_loop_bit = 3;
  localparam int pmir_duplex_bit = 2;
  localparam int pmir_link_bit = 0;
  localparam logic [4:0] pmir_target_vendor = 5'h1f;
  localparam logic [4:0] pmir_target_mmd1 = 5'h01;
  localparam logic [15:0] pmir_vendor_last = 16'h04d1;
  localparam int pmir_mmd_words = 32;
  // Host register byte offsets on the AHB-Lite side.
  localparam logic [7:0] pmir_h_cmd = 8'h00;
  localparam logic [7:0] pmir_h_wdata = 8'h04;
  localparam logic [7:0] pmir_h_rdata = 8'h08;
  localparam logic [7:0] pmir_h_int_status = 8'h0c;
  localparam logic [7:0] pmir_h_int_mask = 8'h10;
  localparam logic [7:0] pmir_h_busy = 8'h14;
  typedef enum logic [1:0] {
    pmir_cmd_addr = 2'h0,
    pmir_cmd_data = 2'h1,
    pmir_cmd_data_inc_rw = 2'h2,
    pmir_cmd_data_inc_w = 2'h3
  } pmir_cmd_t;
endpackage : pmir_pkg

/* File: testbench/pmir_checker.sv */
// Checker of the register link between the host and device ends.
`timescale 1ns/10ps
`default_nettype none
module pmir_checker import pmir_pkg::*; #(
  parameter logic [15:0] id = 16'h0000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata
);
  logic rd;
  assign rd = ack && !wr;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ack_next: assert property (
    $rose(req) |=> ack) else $error("ack late");
  chk_ack_pulse: assert property (
    ack |=> !ack) else $error("ack too long");
  chk_ack_cause: assert property (
    ack |-> $past(req)) else $error("ack without request");
  chk_req_drop: assert property (
    ack |=> !req) else $error("request held after ack");
  chk_req_hold: assert property (
    req && !ack |=> req && $stable(addr) && $stable(wdata))
    else $error("request changed early");
  chk_id_value: assert property (
    rd && addr == pmir_off_id_low |-> rdata == id) else $error("id wrong");
  chk_stat_rsvd: assert property (
    rd && addr == pmir_off_status |-> (rdata & 16'hf972) == 16'h0000)
    else $error("status reserved bits set");
  chk_ctrl_rsvd: assert property (
    rd && addr == pmir_off_ctrl |-> rdata[13:5] == 9'h000)
    else $error("control reserved bits set");
endmodule : pmir_checker
`default_nettype wire

/* File: testbench/test_phy_mgmt_indirect_regs.sv */
// Bench driving the host end over AHB-Lite against the device end.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module test_phy_mgmt_indirect_regs;
  import pmir_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic chan = 0, lock = 0, irqo = 0, loopb = 0, dup = 1, lnk = 0;
  logic [15:0] q;
  int mismatches = 0, tests_run = 0;
  always #2.5 hclk = ~hclk;
  pmir_if pmir_if_inst();
  pmir_host pmir_host_inst(.hclk(hclk), .hresetn(hresetn),
    .bus(pmir_if_inst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
  // Identifier values are arbitrary.
  pmir_device #(.org_low(6'h0b), .model(6'h05), .revision(4'h3))
    pmir_device_inst(.hclk(hclk), .hresetn(hresetn), .bus(pmir_if_inst),
    .chan_ok_in(chan), .lock_in(lock), .irq_out_in(irqo),
    .loopback_in(loopb), .full_duplex_in(dup), .link_in(lnk));
  pmir_checker #(.id(16'h2c53)) pmir_checker_inst(.hclk(hclk),
    .hresetn(hresetn), .req(pmir_if_inst.req), .wr(pmir_if_inst.wr),
    .addr(pmir_if_inst.addr), .wdata(pmir_if_inst.wdata),
    .ack(pmir_if_inst.ack), .rdata(pmir_if_inst.rdata));
  task automatic complete_run();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // Ready is taken at the rising edge, where the slave samples the phase.
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin mismatches++; complete_run(); end
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : ahb
  task automatic dev(input logic w, input logic [4:0] a, input logic [15:0] d,
                     output logic [15:0] r);
    int n;
    ahb(1, pmir_h_wdata, {16'h0, d});
    ahb(1, pmir_h_cmd, {23'h0, w, 3'h0, a});
    n = 0;
    do begin ahb(0, pmir_h_int_status, 0); n++; end
    while (rd[0] !== 1'b1 && n < 20);
    if (rd[0] !== 1'b1) begin mismatches++; complete_run(); end
    ahb(0, pmir_h_rdata, 0);
    r = rd[15:0];
    ahb(1, pmir_h_int_status, 32'h3);
  endtask : dev
  task automatic step(input pmir_cmd_t c, input logic [4:0] dv, input logic w,
                      input logic [15:0] d, input logic [15:0] e);
    dev(1, pmir_off_ctrl, {c, 9'h0, dv}, q);
    dev(w, pmir_off_addr_data, d, q);
    if (!w) `CHK(q, e)
  endtask : step
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    dev(0, pmir_off_status, 0, q); `CHK(q, pmir_status_reset)
    dev(0, pmir_off_id_low, 0, q); `CHK(q, 16'h2c53)
    chan <= 1; lock <= 1; loopb <= 1; lnk <= 1;
    dev(0, pmir_off_status, 0, q); `CHK(q, 16'h000d)
    dev(0, pmir_off_status, 0, q); `CHK(q, 16'h060d)
    for (int i = 0; i < 2; i++) begin
      if (i == 0) chan <= 0; else lock <= 0;
      repeat (4) @(posedge hclk);
      chan <= 1; lock <= 1;
      dev(0, pmir_off_status, 0, q); `CHK(q, i ? 16'h040d : 16'h020d)
      dev(0, pmir_off_status, 0, q); `CHK(q, 16'h060d)
    end
    dev(1, pmir_off_status, 0, q);
    dev(0, pmir_off_status, 0, q); `CHK(q, 16'h060d)
    dup <= 0; lnk <= 0; loopb <= 0; irqo <= 1;
    dev(0, pmir_off_status, 0, q); `CHK(q, 16'h0680)
    dev(0, pmir_off_int_status1, 0, q);
    dev(0, pmir_off_status, 0, q); `CHK(q, 16'h0600)
    step(pmir_cmd_addr, 5'h1f, 1, 16'h0010, 0);
    step(pmir_cmd_data_inc_rw, 5'h1f, 1, 16'haaaa, 0);
    step(pmir_cmd_data_inc_rw, 5'h1f, 1, 16'hbbbb, 0);
    step(pmir_cmd_addr, 5'h01, 1, 16'h0010, 0);
    step(pmir_cmd_data, 5'h01, 1, 16'h1234, 0);
    step(pmir_cmd_addr, 5'h02, 1, 16'h0010, 0);
    step(pmir_cmd_data, 5'h02, 1, 16'h5555, 0);
    step(pmir_cmd_addr, 5'h1f, 0, 0, 16'h0012);
    step(pmir_cmd_addr, 5'h1f, 1, 16'h0010, 0);
    step(pmir_cmd_data, 5'h1f, 0, 0, 16'haaaa);
    step(pmir_cmd_data, 5'h1f, 0, 0, 16'haaaa);
    step(pmir_cmd_data_inc_rw, 5'h1f, 0, 0, 16'haaaa);
    step(pmir_cmd_data_inc_rw, 5'h1f, 0, 0, 16'hbbbb);
    step(pmir_cmd_addr, 5'h1f, 1, 16'h0010, 0);
    step(pmir_cmd_data_inc_w, 5'h1f, 0, 0, 16'haaaa);
    step(pmir_cmd_data_inc_w, 5'h1f, 1, 16'hcccc, 0);
    step(pmir_cmd_data_inc_w, 5'h1f, 0, 0, 16'hbbbb);
    step(pmir_cmd_data, 5'h01, 0, 0, 16'h1234);
    step(pmir_cmd_addr, 5'h1f, 1, 16'h04d2, 0);
    step(pmir_cmd_data, 5'h1f, 1, 16'h7777, 0);
    step(pmir_cmd_data, 5'h1f, 0, 0, 16'h0000);
    dev(0, pmir_off_ctrl, 0, q); `CHK(q, 16'h401f)
    ahb(1, pmir_h_int_mask, 32'h1);
    ahb(1, pmir_h_cmd, {27'h0, pmir_off_id_low});
    repeat (4) @(posedge hclk);
    ahb(0, pmir_h_int_status, 0); `CHK(rd[1:0], 2'h3)
    `CHK(irq, 1'b1)
    ahb(1, pmir_h_int_status, 32'h1);
    ahb(0, pmir_h_int_status, 0); `CHK(rd[1:0], 2'h2)
    `CHK(irq, 1'b0)
    `CHK(hresp, 1'b0)
    complete_run();
  end
endmodule : test_phy_mgmt_indirect_regs
`default_nettype wire
